// ---- t2ar_pkg.sv ----
// Constants shared by the auto-reload and capture timer block
package t2ar_pkg;
	// Register addresses on the special-function-register bus
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
	localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LOW     = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hCD;

	// Field positions inside timer_control
	localparam int unsigned BIT_HIGH_FLAG = 7;
	localparam int unsigned BIT_LOW_FLAG  = 6;
	localparam int unsigned BIT_LOW_IRQEN = 5;
	localparam int unsigned BIT_CAPTURE   = 4;
	localparam int unsigned BIT_SPLIT     = 3;
	localparam int unsigned BIT_RUN       = 2;
	localparam int unsigned BIT_EXT_SEL   = 0;

	// Reset values and byte limits
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BYTE_MAX   = 8'hFF;
	localparam logic [7:0] READ_ZERO  = 8'h00;
	localparam logic       RESET_BIT  = 1'b0;

	// Prescaler ratio for the slow system-clock tick
	localparam int unsigned SYS_DIV = 12;
endpackage : t2ar_pkg

// ---- t2ar_tick.sv ----
// Tick sources: system clock divider and synchronised external clock
`timescale 1ns/1ps
module t2ar_tick #(
	parameter int unsigned DIV = t2ar_pkg::SYS_DIV
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst,
	input  wire logic i_ext_osc_div8,
	output logic      o_tick_div,
	output logic      o_tick_ext,
	output logic      o_capture
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] DIV_ZERO = '0;

	generate
		if (DIV < 2) begin : g_bad_div
			$error("t2ar_tick: DIV must be at least 2");
		end
	endgenerate

	logic [CW-1:0] div_cnt;
	logic          ext_meta;
	logic          ext_sync;
	logic          ext_prev;
	wire           div_wrap = (div_cnt == DIV_LAST);

	// Free-running divider, one-cycle tick every DIV cycles
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_cnt <= DIV_ZERO;
		end else begin
			div_cnt <= div_wrap ? DIV_ZERO : div_cnt + CW'(1);
		end
	end

	// Two-flop synchroniser plus an edge history flop
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ext_meta <= t2ar_pkg::RESET_BIT;
			ext_sync <= t2ar_pkg::RESET_BIT;
			ext_prev <= t2ar_pkg::RESET_BIT;
		end else begin
			ext_meta <= i_ext_osc_div8;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// Rising edge counts, falling edge captures
	assign o_tick_div = div_wrap;
	assign o_tick_ext = ext_sync & ~ext_prev;
	assign o_capture  = ~ext_sync & ext_prev;
endmodule : t2ar_tick

// ---- t2ar_byte.sv ----
// One 8-bit counter byte with write, reload and increment
`timescale 1ns/1ps
module t2ar_byte (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_load,
	input  wire logic [7:0] i_load_val,
	input  wire logic       i_inc,
	output logic [7:0]      o_count,
	output logic            o_wrap
);
	// Wrap is an increment while the byte holds all ones
	assign o_wrap = i_inc & (o_count == t2ar_pkg::BYTE_MAX);

	// Software write first, then reload, then a single-step increment
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_count <= t2ar_pkg::RESET_BYTE;
		end else if (i_wr) begin
			o_count <= i_wdata;
		end else if (i_load) begin
			o_count <= i_load_val;
		end else if (i_inc) begin
			o_count <= o_count + 8'h01;
		end
	end
endmodule : t2ar_byte

// ---- t2ar_timer.sv ----
// Timer top: control register, clock selection, reload, capture, interrupt
`timescale 1ns/1ps
module t2ar_timer #(
	parameter int unsigned SYS_DIV = t2ar_pkg::SYS_DIV
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic       i_sfr_wr,
	input  wire logic [7:0] i_sfr_wdata,
	input  wire logic       i_timer_irq_enable,
	input  wire logic       i_high_byte_clock_select,
	input  wire logic       i_low_byte_clock_select,
	input  wire logic       i_ext_osc_div8,
	output logic [7:0]      o_sfr_rdata,
	output logic            o_timer_irq
);
	// Control register fields, reload bytes and count bytes
	logic       high_overflow_flag;
	logic       low_overflow_flag;
	logic       low_overflow_irq_enable;
	logic       capture_enable;
	logic       split_mode_select;
	logic       run_control;
	logic       external_clock_select;
	logic [7:0] reload_low_byte;
	logic [7:0] reload_high_byte;
	logic [7:0] count_low_byte;
	logic [7:0] count_high_byte;

	// Tick sources
	wire tick_div;
	wire tick_ext;
	wire capture_edge;

	t2ar_tick #(
		.DIV (SYS_DIV)
	) u_tick (
		.i_sys_clk      (i_sys_clk),
		.i_rst          (i_rst),
		.i_ext_osc_div8 (i_ext_osc_div8),
		.o_tick_div     (tick_div),
		.o_tick_ext     (tick_ext),
		.o_capture      (capture_edge)
	);

	// Address decode
	wire wr_ctrl = i_sfr_wr & (i_sfr_addr == t2ar_pkg::ADDR_TIMER_CONTROL);
	wire wr_rll  = i_sfr_wr & (i_sfr_addr == t2ar_pkg::ADDR_RELOAD_LOW);
	wire wr_rlh  = i_sfr_wr & (i_sfr_addr == t2ar_pkg::ADDR_RELOAD_HIGH);
	wire wr_cl   = i_sfr_wr & (i_sfr_addr == t2ar_pkg::ADDR_COUNT_LOW);
	wire wr_ch   = i_sfr_wr & (i_sfr_addr == t2ar_pkg::ADDR_COUNT_HIGH);

	// Clock selection; external-select picks divided system or external tick, but capture mode gives the low byte the divided tick
	wire ext_choice = external_clock_select ? tick_ext : tick_div;
	wire cap_choice = tick_div;
	wire low_alt    = capture_enable ? cap_choice : ext_choice;
	wire tick_low   = i_low_byte_clock_select | low_alt;
	wire tick_high  = i_high_byte_clock_select | ext_choice;

	// Increment enables per mode
	wire low_wrap;
	wire high_wrap;
	wire low_inc  = split_mode_select | run_control ? tick_low & (split_mode_select | run_control)
		: 1'b0;
	wire high_inc = split_mode_select ? run_control & tick_high
		: low_wrap;
	wire full_wrap = ~split_mode_select & high_wrap;
	wire low_load  = split_mode_select ? low_wrap : full_wrap;
	wire high_load = split_mode_select ? high_wrap : full_wrap;
	wire capture   = capture_enable & capture_edge;

	// Hardware flag sets
	wire set_high = high_wrap | capture;
	wire set_low  = low_wrap;

	t2ar_byte u_low (
		.i_sys_clk  (i_sys_clk),
		.i_rst      (i_rst),
		.i_wr       (wr_cl),
		.i_wdata    (i_sfr_wdata),
		.i_load     (low_load),
		.i_load_val (reload_low_byte),
		.i_inc      (low_inc),
		.o_count    (count_low_byte),
		.o_wrap     (low_wrap)
	);

	t2ar_byte u_high (
		.i_sys_clk  (i_sys_clk),
		.i_rst      (i_rst),
		.i_wr       (wr_ch),
		.i_wdata    (i_sfr_wdata),
		.i_load     (high_load),
		.i_load_val (reload_high_byte),
		.i_inc      (high_inc),
		.o_count    (count_high_byte),
		.o_wrap     (high_wrap)
	);

	// Next flag values: a set in the same cycle wins over a written zero
	wire next_high_flag = set_high | (wr_ctrl ? i_sfr_wdata[t2ar_pkg::BIT_HIGH_FLAG]
		: high_overflow_flag);
	wire next_low_flag  = set_low | (wr_ctrl ? i_sfr_wdata[t2ar_pkg::BIT_LOW_FLAG]
		: low_overflow_flag);

	// Control register storage; bit 1 is not stored
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			high_overflow_flag      <= t2ar_pkg::RESET_BIT;
			low_overflow_flag       <= t2ar_pkg::RESET_BIT;
			low_overflow_irq_enable <= t2ar_pkg::RESET_BIT;
			capture_enable          <= t2ar_pkg::RESET_BIT;
			split_mode_select       <= t2ar_pkg::RESET_BIT;
			run_control             <= t2ar_pkg::RESET_BIT;
			external_clock_select   <= t2ar_pkg::RESET_BIT;
		end else begin
			high_overflow_flag <= next_high_flag;
			low_overflow_flag  <= next_low_flag;
			if (wr_ctrl) begin
				low_overflow_irq_enable <= i_sfr_wdata[t2ar_pkg::BIT_LOW_IRQEN];
				capture_enable          <= i_sfr_wdata[t2ar_pkg::BIT_CAPTURE];
				split_mode_select       <= i_sfr_wdata[t2ar_pkg::BIT_SPLIT];
				run_control             <= i_sfr_wdata[t2ar_pkg::BIT_RUN];
				external_clock_select   <= i_sfr_wdata[t2ar_pkg::BIT_EXT_SEL];
			end
		end
	end

	// Reload registers: capture beats a software write in the same cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			reload_low_byte  <= t2ar_pkg::RESET_BYTE;
			reload_high_byte <= t2ar_pkg::RESET_BYTE;
		end else if (capture) begin
			reload_low_byte  <= count_low_byte;
			reload_high_byte <= count_high_byte;
		end else begin
			if (wr_rll) begin
				reload_low_byte <= i_sfr_wdata;
			end
			if (wr_rlh) begin
				reload_high_byte <= i_sfr_wdata;
			end
		end
	end

	// Read data selection
	wire [7:0] ctrl_view = {high_overflow_flag, low_overflow_flag,
		low_overflow_irq_enable, capture_enable, split_mode_select,
		run_control, 1'b0, external_clock_select};
	wire [7:0] read_mux =
		(i_sfr_addr == t2ar_pkg::ADDR_TIMER_CONTROL) ? ctrl_view :
		(i_sfr_addr == t2ar_pkg::ADDR_RELOAD_LOW)    ? reload_low_byte :
		(i_sfr_addr == t2ar_pkg::ADDR_RELOAD_HIGH)   ? reload_high_byte :
		(i_sfr_addr == t2ar_pkg::ADDR_COUNT_LOW)     ? count_low_byte :
		(i_sfr_addr == t2ar_pkg::ADDR_COUNT_HIGH)    ? count_high_byte :
		t2ar_pkg::READ_ZERO;

	// Interrupt request under the global enable: high flag always, low flag only with its enable
	wire next_irq = i_timer_irq_enable & (high_overflow_flag
		| (low_overflow_flag & low_overflow_irq_enable));

	// Registered outputs
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_sfr_rdata <= t2ar_pkg::READ_ZERO;
			o_timer_irq <= t2ar_pkg::RESET_BIT;
		end else begin
			o_sfr_rdata <= read_mux;
			o_timer_irq <= next_irq;
		end
	end

	// Checks beside the logic
	a_full_reload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		full_wrap && !wr_cl && !wr_ch |=> count_low_byte == $past(reload_low_byte)
		&& count_high_byte == $past(reload_high_byte) && high_overflow_flag)
		else $error("16-bit wrap did not reload or flag");

	a_irq_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_timer_irq_enable && high_overflow_flag |=> o_timer_irq)
		else $error("high flag did not raise interrupt");

	a_irq_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_timer_irq_enable && low_overflow_flag && low_overflow_irq_enable
		|=> o_timer_irq)
		else $error("low flag with enable did not interrupt");

	a_irq_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!i_timer_irq_enable || (!high_overflow_flag && !low_overflow_flag)
		|=> !o_timer_irq)
		else $error("interrupt without enabled source");

	a_split_low_run: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		split_mode_select && !run_control && i_low_byte_clock_select && !wr_cl
		&& !low_wrap |=> count_low_byte == $past(count_low_byte) + 8'h01)
		else $error("low byte stalled in split mode");

	a_stop_16: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!split_mode_select && !run_control && !wr_cl && !wr_ch
		|=> $stable(count_low_byte) && $stable(count_high_byte))
		else $error("16-bit timer moved while stopped");

	a_split_reload: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		split_mode_select && high_wrap && !wr_ch
		|=> count_high_byte == $past(reload_high_byte) && high_overflow_flag)
		else $error("split high byte wrap mishandled");

	a_low_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		low_wrap |=> low_overflow_flag)
		else $error("low wrap did not set low flag");

	a_flag_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		high_overflow_flag && !wr_ctrl |=> high_overflow_flag)
		else $error("high flag cleared without a write");

	a_capture: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		capture |=> reload_low_byte == $past(count_low_byte)
		&& reload_high_byte == $past(count_high_byte) && high_overflow_flag)
		else $error("capture did not copy count");

	a_bit1_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_sfr_addr == t2ar_pkg::ADDR_TIMER_CONTROL ##1 1'b1 |-> !o_sfr_rdata[1])
		else $error("unused control bit read as one");

	a_count_read: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_sfr_addr == t2ar_pkg::ADDR_COUNT_HIGH |=> o_sfr_rdata == $past(count_high_byte))
		else $error("count high read mismatch");

	a_flag_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_ctrl && !i_sfr_wdata[t2ar_pkg::BIT_HIGH_FLAG] && !set_high
		|=> !high_overflow_flag)
		else $error("written zero did not clear high flag");

	a_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_ctrl && set_low |=> low_overflow_flag)
		else $error("flag clear beat a hardware set");

	a_count_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_cl |=> count_low_byte == $past(i_sfr_wdata))
		else $error("count low write did not land");

	a_mode_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		wr_ctrl |=> capture_enable == $past(i_sfr_wdata[t2ar_pkg::BIT_CAPTURE])
		&& split_mode_select == $past(i_sfr_wdata[t2ar_pkg::BIT_SPLIT]))
		else $error("mode bits did not follow the write");

	a_high_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!split_mode_select && !low_wrap && !wr_ch |=> $stable(count_high_byte))
		else $error("high byte moved without a low wrap");

	a_sys_tick: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!split_mode_select && run_control && i_low_byte_clock_select && !wr_cl
		&& !low_wrap |=> count_low_byte == $past(count_low_byte) + 8'h01)
		else $error("system clock did not step the count");

	a_div_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!split_mode_select && !i_low_byte_clock_select && !external_clock_select
		&& !tick_div && !wr_cl |=> $stable(count_low_byte))
		else $error("count moved between divided ticks");

	a_ext_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!split_mode_select && !i_low_byte_clock_select && external_clock_select
		&& !capture_enable && !tick_ext && !wr_cl |=> $stable(count_low_byte))
		else $error("count moved without a synchronised edge");

	a_capture_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!capture_edge && !wr_rll |=> $stable(reload_low_byte))
		else $error("reload changed without a falling edge");

	a_split_high: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		split_mode_select && run_control && i_high_byte_clock_select && !wr_ch
		&& !high_wrap |=> count_high_byte == $past(count_high_byte) + 8'h01)
		else $error("high byte ignored its clock select");

	a_split_irq: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		split_mode_select && i_timer_irq_enable && !high_overflow_flag
		&& !low_overflow_irq_enable |=> !o_timer_irq)
		else $error("low flag interrupted without its enable");
endmodule : t2ar_timer

// ---- t2ar_timer_tb_top.sv ----
// Self-checking testbench for the auto-reload and capture timer
`timescale 1ns/1ps
module t2ar_timer_tb_top;
	localparam logic [7:0] A_CTL = t2ar_pkg::ADDR_TIMER_CONTROL;
	localparam logic [7:0] A_RL  = t2ar_pkg::ADDR_RELOAD_LOW;
	localparam logic [7:0] A_RH  = t2ar_pkg::ADDR_RELOAD_HIGH;
	localparam logic [7:0] A_CL  = t2ar_pkg::ADDR_COUNT_LOW;
	localparam logic [7:0] A_CH  = t2ar_pkg::ADDR_COUNT_HIGH;
	logic       clk, rst, wr, ie, hsel, lsel, ext, irq;
	logic [7:0] addr, wdata, rdata, v, c;
	int         mismatches, total_checks;

	t2ar_timer #(.SYS_DIV(12)) dut (
		.i_sys_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_wdata(wdata), .i_timer_irq_enable(ie), .i_high_byte_clock_select(hsel),
		.i_low_byte_clock_select(lsel), .i_ext_osc_div8(ext), .o_sfr_rdata(rdata),
		.o_timer_irq(irq)
	);

	// Clock generation
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare one value and count the outcome
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: value %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// One register write cycle
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg

	// Read data comes one cycle after the address
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		@(negedge clk);
		d = rdata;
	endtask : rreg

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rreg(a, d);
		check(d, exp);
	endtask : chk_reg

	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask : ticks

	// Reset values, unmapped address and unused control bit
	task automatic t_reset();
		chk_reg(A_CTL, 8'h00);
		chk_reg(A_RL, 8'h00);
		chk_reg(A_RH, 8'h00);
		chk_reg(A_CL, 8'h00);
		chk_reg(A_CH, 8'h00);
		wreg(8'h00, 8'hAA);
		chk_reg(8'h00, 8'h00);
		wreg(A_CTL, 8'h02);
		chk_reg(A_CTL, 8'h00);
		$display("test reset done");
	endtask : t_reset

	// Five run cycles give exactly five increments, then the count holds
	task automatic t_inc();
		lsel = 1'b1;
		wreg(A_CL, 8'h10);
		wreg(A_CTL, 8'h04);
		ticks(3);
		wreg(A_CTL, 8'h00);
		chk_reg(A_CL, 8'h15);
		ticks(4);
		chk_reg(A_CL, 8'h15);
		$display("test increment done");
	endtask : t_inc

	// 16-bit wrap, reload, flags and interrupt
	task automatic t_wrap16();
		ie = 1'b1;
		wreg(A_RL, 8'h34);
		wreg(A_RH, 8'h12);
		wreg(A_CL, 8'hFD);
		wreg(A_CH, 8'hFE);
		wreg(A_CTL, 8'h04);
		ticks(8);
		chk_reg(A_CTL, 8'h44);
		check({7'h00, irq}, 8'h00);
		ticks(260);
		chk_reg(A_CTL, 8'hC4);
		check({7'h00, irq}, 8'h01);
		ticks(20);
		chk_reg(A_CTL, 8'hC4);
		wreg(A_CTL, 8'h24);
		ticks(260);
		chk_reg(A_CTL, 8'h64);
		check({7'h00, irq}, 8'h01);
		wreg(A_CTL, 8'h00);
		chk_reg(A_CH, 8'h13);
		check({7'h00, irq}, 8'h00);
		$display("test wrap16 done");
	endtask : t_wrap16

	// Divided and external clocks; high select ignored outside split
	task automatic t_clk();
		lsel = 1'b0;
		hsel = 1'b1;
		wreg(A_CL, 8'h00);
		wreg(A_CH, 8'h00);
		wreg(A_CTL, 8'h04);
		ticks(118);
		wreg(A_CTL, 8'h00);
		chk_reg(A_CL, 8'h0A);
		chk_reg(A_CH, 8'h00);
		wreg(A_CL, 8'h00);
		wreg(A_CTL, 8'h05);
		ticks(2);
		repeat (4) begin
			ext = 1'b1;
			ticks(4);
			ext = 1'b0;
			ticks(4);
		end
		ticks(6);
		wreg(A_CTL, 8'h00);
		chk_reg(A_CL, 8'h04);
		$display("test clock select done");
	endtask : t_clk

	// Two 8-bit counters with their own reloads, flags and interrupts
	task automatic t_split();
		lsel = 1'b1;
		wreg(A_RL, 8'hF8);
		wreg(A_RH, 8'h40);
		wreg(A_CL, 8'hFE);
		wreg(A_CH, 8'hFE);
		wreg(A_CTL, 8'h08);
		ticks(10);
		chk_reg(A_CH, 8'hFE);
		chk_reg(A_CTL, 8'h48);
		check({7'h00, irq}, 8'h00);
		wreg(A_CTL, 8'h68);
		ticks(1);
		check({7'h00, irq}, 8'h01);
		wreg(A_CTL, 8'h0C);
		ticks(10);
		chk_reg(A_CTL, 8'hCC);
		check({7'h00, irq}, 8'h01);
		rreg(A_CH, v);
		check(v & 8'hF0, 8'h40);
		rreg(A_CL, v);
		check(v & 8'hF8, 8'hF8);
		wreg(A_CTL, 8'h00);
		$display("test split done");
	endtask : t_split

	// Capture on the falling edge only, counting the system clock
	task automatic t_capture();
		lsel = 1'b1;
		wreg(A_CH, 8'h55);
		wreg(A_CL, 8'h00);
		wreg(A_RL, 8'h00);
		wreg(A_RH, 8'h00);
		wreg(A_CTL, 8'h14);
		ext = 1'b1;
		ticks(8);
		chk_reg(A_CTL, 8'h14);
		ext = 1'b0;
		ticks(8);
		chk_reg(A_CTL, 8'h94);
		chk_reg(A_RH, 8'h55);
		rreg(A_RL, v);
		wreg(A_CTL, 8'h00);
		rreg(A_CL, c);
		check(8'(v > 8'h08 && v < c), 8'h01);
		lsel = 1'b0;
		wreg(A_CL, 8'h00);
		wreg(A_CTL, 8'h15);
		ticks(118);
		wreg(A_CTL, 8'h00);
		chk_reg(A_CL, 8'h0A);
		$display("test capture done");
	endtask : t_capture

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Main sequence
	initial begin
		mismatches = 0;
		total_checks = 0;
		rst = 1'b1;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		ie = 1'b0;
		hsel = 1'b0;
		lsel = 1'b0;
		ext = 1'b0;
		ticks(5);
		rst = 1'b0;
		t_reset();
		t_inc();
		t_wrap16();
		t_clk();
		t_split();
		t_capture();
		complete_run();
	end

	// Watchdog against a hung run
	initial begin
		#60000;
		mismatches++;
		complete_run();
	end
endmodule : t2ar_timer_tb_top
